// ### pkg/chan_mgmt_pkg.sv
// constants, types and field layout for the channel reset and status register pair
// assumes a management host on a two-wire serial management bus (clause 45 framing)
package chan_mgmt_pkg;

	localparam logic [15:0] REG_SOFT_RESET     = 16'h000E;
	localparam logic [15:0] REG_LINK_STATUS    = 16'h000F;
	localparam logic [15:0] SOFT_RESET_DEFAULT = 16'h0000;
	localparam logic [15:0] STATUS_DEFAULT     = 16'h0000;
	localparam logic [15:0] ADDR_DEFAULT       = 16'h0000;
	localparam logic [15:0] WORD_ZERO          = 16'h0000;
	localparam logic [15:0] ADDR_STEP          = 16'h0001;

	// writable bits of the reset control word; 15:8 never stored
	localparam logic [15:0] SOFT_RESET_WMASK   = 16'h00FF;
	localparam logic [15:0] SOFT_RESET_SCMASK  = 16'h000E;
	localparam int          BIT_DATAPATH_RST   = 3;
	localparam int          BIT_TX_CLEAR       = 2;
	localparam int          BIT_RX_CLEAR       = 1;

	localparam logic [4:0]  DEVICE_ADDR        = 5'h1E;
	localparam logic [5:0]  PREAMBLE_LEN       = 6'h20;
	localparam logic [5:0]  PREAMBLE_ZERO      = 6'h00;
	localparam logic [5:0]  PREAMBLE_STEP      = 6'h01;
	localparam logic [4:0]  HEADER_LAST        = 5'h0B;
	localparam logic [4:0]  DATA_LAST          = 5'h0F;
	localparam logic [4:0]  TA_LAST            = 5'h01;
	localparam logic [4:0]  CNT_ZERO           = 5'h00;
	localparam logic [4:0]  CNT_STEP           = 5'h01;

	typedef enum logic [1:0]
	{
		OP_ADDRESS  = 2'b00,
		OP_WRITE    = 2'b01,
		OP_READ_INC = 2'b10,
		OP_READ     = 2'b11
	} mgmt_op_t;

	typedef enum logic [1:0]
	{
		MODE_10G   = 2'b00,
		MODE_10GKR = 2'b01,
		MODE_1GKX  = 2'b10,
		MODE_OTHER = 2'b11
	} chan_mode_t;

	typedef enum logic [2:0]
	{
		ST_PREAMBLE = 3'b000,
		ST_START    = 3'b001,
		ST_HEADER   = 3'b010,
		ST_WR_TA    = 3'b011,
		ST_WR_DATA  = 3'b100,
		ST_RD_TA    = 3'b101,
		ST_RD_DATA  = 3'b110
	} mgmt_state_t;

	// raw channel indications, in register polarity, bit 9 slot left out
	typedef struct packed
	{
		logic pattern_check_ok;
		logic system_lane_align_flag;
		logic line_signal_lost;
		logic autozero_cal_complete;
		logic gain_loop_locked;
		logic line_sync_achieved;
		logic bad_codeword_seen;
		logic tx_underflow;
		logic tx_overflow;
		logic rx_underflow;
		logic rx_overflow;
		logic rx_link_ok;
		logic tx_link_ok;
		logic system_pll_locked;
		logic line_pll_locked;
	} chan_status_t;

	// reset pulses toward the channel datapath
	typedef struct packed
	{
		logic datapath_reset;
		logic tx_buffer_clear;
		logic rx_buffer_clear;
	} chan_resets_t;

endpackage : chan_mgmt_pkg

// ### verilog/sync_bank.sv
// two-stage synchroniser bank for pins arriving from outside the sys_clk domain
// assumes each bit is an independent level; no multi-bit coherence is promised
`timescale 1ns/1ps

module sync_bank
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// stage1 feeds only the second flop
			always_ff @(posedge sys_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					stage1[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					stage1[i]   <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate

endmodule : sync_bank

// ### verilog/chan_mgmt_regs.sv
// serial management slave holding the channel reset control and channel status words
// assumes mdc and mdio come from an external host, so both are synchronised to sys_clk;
// mdc must be well below sys_clk / 4
// reset pulses last one mdc period; a host that stops mdc leaves them asserted
`timescale 1ns/1ps

module chan_mgmt_regs
	import chan_mgmt_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = 5'h00
)
(
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         mdc,
	input  wire logic         mdio_in,
	output logic              mdio_out,
	output logic              mdio_oe,
	input  wire logic [1:0]   chan_mode,
	input  wire chan_status_t chan_status,
	output chan_resets_t      chan_resets
);

	localparam int STAT_W = $bits(chan_status_t);
	localparam int SYNC_W = STAT_W + 4;

	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_q;
	chan_status_t      stat_s;
	chan_mode_t        mode_s;
	logic              mdc_s;
	logic              mdio_s;
	logic              mdc_prev;
	logic              next_mdc_prev;
	logic              mdc_rise;
	logic [15:0]       status_word;

	mgmt_state_t       state;
	mgmt_state_t       next_state;
	logic [5:0]        pre_cnt;
	logic [5:0]        next_pre_cnt;
	logic [4:0]        bit_cnt;
	logic [4:0]        next_bit_cnt;
	logic [15:0]       shift;
	logic [15:0]       next_shift;
	mgmt_op_t          op;
	mgmt_op_t          next_op;
	logic [15:0]       addr;
	logic [15:0]       next_addr;
	logic [15:0]       soft_reset_reg;
	logic [15:0]       next_soft_reset_reg;
	logic              drive;
	logic              next_drive;
	logic              out_bit;
	logic              next_out_bit;
	chan_resets_t      resets_q;
	chan_resets_t      next_resets_q;
	logic [15:0]       link_status_flags;
	logic [15:0]       read_word;
	logic [15:0]       hdr;
	logic              hdr_match;
	logic              is_10g;
	logic              underflow_valid;
	logic              pattern_valid;

	// everything from outside the clock domain shares one synchroniser bank
	assign sync_raw = {mdc, mdio_in, chan_mode, chan_status};

	sync_bank #(
		.WIDTH(SYNC_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (sync_raw),
		.sync_out (sync_q)
	);

	assign mdc_s  = sync_q[SYNC_W-1];
	assign mdio_s = sync_q[SYNC_W-2];
	assign mode_s = chan_mode_t'(sync_q[STAT_W+1:STAT_W]);
	assign stat_s = chan_status_t'(sync_q[STAT_W-1:0]);

	// edge detect reads the second flop only, never the first
	always_comb
	begin
		next_mdc_prev = mdc_s;
	end

	// reset level matches the idle-low clock pin, so no false edge follows reset
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			mdc_prev <= 1'b0;
		else
			mdc_prev <= next_mdc_prev;
	end

	assign mdc_rise = mdc_s & ~mdc_prev;

	// mode qualifiers for the status and buffer-reset bits
	assign is_10g          = (mode_s == MODE_10G);
	assign pattern_valid   = (mode_s == MODE_10G) || (mode_s == MODE_1GKX);
	assign underflow_valid = (mode_s != MODE_1GKX);

	// status word; flops in the synchroniser reset to zero, so the word is zero only until chan_status has passed both stages
	always_comb
	begin
		link_status_flags     = STATUS_DEFAULT;
		link_status_flags[15] = stat_s.pattern_check_ok & pattern_valid;
		link_status_flags[14] = stat_s.system_lane_align_flag;
		link_status_flags[13] = stat_s.line_signal_lost;
		link_status_flags[12] = stat_s.autozero_cal_complete;
		link_status_flags[11] = stat_s.gain_loop_locked;
		link_status_flags[10] = stat_s.line_sync_achieved;
		// bit 9 has no source and keeps its default zero
		link_status_flags[8]  = stat_s.bad_codeword_seen;
		link_status_flags[7]  = stat_s.tx_underflow & underflow_valid;
		link_status_flags[6]  = stat_s.tx_overflow;
		link_status_flags[5]  = stat_s.rx_underflow & underflow_valid;
		link_status_flags[4]  = stat_s.rx_overflow;
		link_status_flags[3]  = stat_s.rx_link_ok;
		link_status_flags[2]  = stat_s.tx_link_ok;
		link_status_flags[1]  = stat_s.system_pll_locked;
		link_status_flags[0]  = stat_s.line_pll_locked;
		status_word           = link_status_flags;
	end

	// read mux; unmapped addresses read zero
	// the reset word is masked again here, so the high byte can never read back
	always_comb
	begin
		case (addr)
			REG_SOFT_RESET:  read_word = soft_reset_reg & SOFT_RESET_WMASK;
			REG_LINK_STATUS: read_word = status_word;
			default:         read_word = WORD_ZERO;
		endcase
	end

	// header bits as they will be after this edge's shift
	assign hdr       = {shift[14:0], mdio_s};
	// frames for another port or device fall back to hunting for a preamble
	assign hdr_match = (hdr[9:5] == PORT_ADDR) && (hdr[4:0] == DEVICE_ADDR);

	always_comb
	begin
		next_state          = state;
		next_pre_cnt        = pre_cnt;
		next_bit_cnt        = bit_cnt;
		next_shift          = shift;
		next_op             = op;
		next_addr           = addr;
		next_soft_reset_reg = soft_reset_reg;
		next_drive          = drive;
		next_out_bit        = out_bit;
		next_resets_q       = resets_q;
		if (mdc_rise)
		begin
			// self-clearing bits drop on the mdc edge after the one that set them
			next_soft_reset_reg = soft_reset_reg & ~SOFT_RESET_SCMASK;
			case (state)
				ST_PREAMBLE:
				begin
					next_drive = 1'b0;
					if (mdio_s)
					begin
						// count saturates, so a longer run of ones is still accepted
						if (pre_cnt != PREAMBLE_LEN)
							next_pre_cnt = pre_cnt + PREAMBLE_STEP;
					end
					else if (pre_cnt == PREAMBLE_LEN)
					begin
						next_pre_cnt = PREAMBLE_ZERO;
						next_state   = ST_START;
					end
					else
						next_pre_cnt = PREAMBLE_ZERO;
				end
				ST_START:
				begin
					// a second zero marks an extended frame; a one is a frame type this slave ignores
					next_bit_cnt = CNT_ZERO;
					next_state   = mdio_s ? ST_PREAMBLE : ST_HEADER;
				end
				ST_HEADER:
				begin
					next_shift   = hdr;
					next_bit_cnt = bit_cnt + CNT_STEP;
					if (bit_cnt == HEADER_LAST)
					begin
						next_op      = mgmt_op_t'(hdr[11:10]);
						next_bit_cnt = CNT_ZERO;
						if (!hdr_match)
							next_state = ST_PREAMBLE;
						else if (hdr[11])
							next_state = ST_RD_TA;
						else
							next_state = ST_WR_TA;
					end
				end
				ST_WR_TA:
				begin
					next_bit_cnt = bit_cnt + CNT_STEP;
					if (bit_cnt == TA_LAST)
					begin
						next_bit_cnt = CNT_ZERO;
						next_state   = ST_WR_DATA;
					end
				end
				ST_WR_DATA:
				begin
					next_shift   = hdr;
					next_bit_cnt = bit_cnt + CNT_STEP;
					if (bit_cnt == DATA_LAST)
					begin
						next_state = ST_PREAMBLE;
						if (op == OP_ADDRESS)
							next_addr = hdr;
						else if (addr == REG_SOFT_RESET)
							next_soft_reset_reg = hdr & SOFT_RESET_WMASK;
						// a write to the status word or any other address is dropped
					end
				end
				ST_RD_TA:
				begin
					// host floats the first turnaround bit; the slave drives zero in the second
					next_bit_cnt = bit_cnt + CNT_STEP;
					if (bit_cnt == CNT_ZERO)
					begin
						next_drive   = 1'b1;
						next_out_bit = 1'b0;
					end
					else
					begin
						next_shift   = {read_word[14:0], 1'b0};
						next_out_bit = read_word[15];
						next_bit_cnt = CNT_ZERO;
						next_state   = ST_RD_DATA;
					end
				end
				ST_RD_DATA:
				begin
					next_bit_cnt = bit_cnt + CNT_STEP;
					next_out_bit = shift[15];
					next_shift   = {shift[14:0], 1'b0};
					if (bit_cnt == DATA_LAST)
					begin
						next_drive   = 1'b0;
						next_out_bit = 1'b0;
						next_state   = ST_PREAMBLE;
						// bumped only after the word is out, so the next read sees the following register
						if (op == OP_READ_INC)
							next_addr = addr + ADDR_STEP;
					end
				end
				default:
				begin
					next_state = ST_PREAMBLE;
					next_drive = 1'b0;
				end
			endcase
		end
		// registered reset outputs follow the stored bits; buffer resets only act in 10G mode
		next_resets_q.datapath_reset  = next_soft_reset_reg[BIT_DATAPATH_RST];
		next_resets_q.tx_buffer_clear = next_soft_reset_reg[BIT_TX_CLEAR] & is_10g;
		next_resets_q.rx_buffer_clear = next_soft_reset_reg[BIT_RX_CLEAR] & is_10g;
	end

	// sys_rst clears this engine; datapath_reset itself never touches these registers
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state          <= ST_PREAMBLE;
			pre_cnt        <= PREAMBLE_ZERO;
			bit_cnt        <= CNT_ZERO;
			shift          <= WORD_ZERO;
			op             <= OP_ADDRESS;
			addr           <= ADDR_DEFAULT;
			soft_reset_reg <= SOFT_RESET_DEFAULT;
			drive          <= 1'b0;
			out_bit        <= 1'b0;
			resets_q       <= '0;
		end
		else
		begin
			state          <= next_state;
			pre_cnt        <= next_pre_cnt;
			bit_cnt        <= next_bit_cnt;
			shift          <= next_shift;
			op             <= next_op;
			addr           <= next_addr;
			soft_reset_reg <= next_soft_reset_reg;
			drive          <= next_drive;
			out_bit        <= next_out_bit;
			resets_q       <= next_resets_q;
		end
	end

	// pins come straight from flops, so nothing glitches toward the wire
	assign mdio_out    = out_bit;
	assign mdio_oe     = drive;
	assign chan_resets = resets_q;

endmodule : chan_mgmt_regs

// ### verification/chan_mgmt_regs_chk.sv
// checker for the channel reset and status register pair, bound to chan_mgmt_regs
// assumes the host keeps each mdc phase at least 4 sys_clk long
`timescale 1ns/1ps

module chan_mgmt_regs_chk
	import chan_mgmt_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         mdc,
	input  wire logic         mdio_in,
	input  wire logic         mdio_out,
	input  wire logic         mdio_oe,
	input  wire logic [1:0]   chan_mode,
	input  wire chan_status_t chan_status,
	input  wire chan_resets_t chan_resets
);
	logic [3:0] since_rise;
	logic [3:0] next_since_rise;
	logic       mdc_q;

	// outputs may only move a few clocks after an mdc rise, never on the fall
	always_comb
	begin
		next_since_rise = (since_rise == 4'hF) ? since_rise : since_rise + 4'h1;
		if (mdc && !mdc_q)
			next_since_rise = 4'h0;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			since_rise <= 4'hF;
			mdc_q      <= 1'b0;
		end
		else
		begin
			since_rise <= next_since_rise;
			mdc_q      <= mdc;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	chk_reset_quiet: assert property ($fell(sys_rst) |-> chan_resets == 3'b000 && !mdio_oe)
		else $error("outputs active right after reset");
	chk_datapath_width: assert property ($rose(chan_resets.datapath_reset) |=>
		chan_resets.datapath_reset[*6] ##[1:40] !chan_resets.datapath_reset)
		else $error("datapath reset pulse length wrong");
	chk_any_width: assert property ($rose(|chan_resets) |=> (|chan_resets)[*6] ##[1:40] !(|chan_resets))
		else $error("reset pulse length wrong");
	chk_buffer_gate: assert property ((chan_mode != MODE_10G)[*4] |->
		!chan_resets.tx_buffer_clear && !chan_resets.rx_buffer_clear)
		else $error("buffer clear outside 10G mode");
	chk_oe_span: assert property ($rose(mdio_oe) |=> mdio_oe[*8] ##[1:1000] !mdio_oe)
		else $error("read drive window wrong");
	chk_out_on_mdc: assert property ($changed(mdio_out) |-> since_rise <= 4'h5)
		else $error("read data moved off an mdc rise");
	chk_oe_on_mdc: assert property ($changed(mdio_oe) |-> since_rise <= 4'h5)
		else $error("drive enable moved off an mdc rise");
	chk_resets_on_mdc: assert property ($changed(chan_resets) |-> since_rise <= 4'h5)
		else $error("reset pulse moved off an mdc rise");
	chk_read_write_apart: assert property (mdio_oe |-> chan_resets == 3'b000)
		else $error("reset pulse during a read");
endmodule : chan_mgmt_regs_chk

bind chan_mgmt_regs chan_mgmt_regs_chk chk_i
(
	.sys_clk     (sys_clk),
	.sys_rst     (sys_rst),
	.mdc         (mdc),
	.mdio_in     (mdio_in),
	.mdio_out    (mdio_out),
	.mdio_oe     (mdio_oe),
	.chan_mode   (chan_mode),
	.chan_status (chan_status),
	.chan_resets (chan_resets)
);

// ### verification/mgmt_host_model.sv
// management host model: sends one clause-45 frame per call on mdc and mdio
// assumes the bench resolves the wire; mdc idles low and the data line is released between frames
`timescale 1ns/1ps

module mgmt_host_model
	import chan_mgmt_pkg::*;
(
	input  wire logic sys_clk,
	output logic      mdc,
	output logic      mdio_drv,
	input  wire logic mdio_wire
);
	initial
	begin
		mdc      = 1'b0;
		mdio_drv = 1'b1;
	end

	// half sets the mdc phase length in sys_clk cycles, so the slave sees fast and slow hosts
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] wd,
		input int half, output logic [15:0] rd);
		logic [63:0] bits;
		int          i;
		bits = {32'hFFFFFFFF, 2'b00, op, pa, DEVICE_ADDR, 2'b10, wd};
		// index -1 is one spare mdc cycle so a self-clearing bit can drop
		for (i = 63; i >= -1; i--)
		begin
			mdc      = 1'b0;
			mdio_drv = (i < 0 || (op[1] && i < 18)) ? 1'b1 : bits[i];
			repeat (half) @(negedge sys_clk);
			// taken just before the rise, while the slave still holds the bit
			if (i >= 0 && i < 16)
				rd[i] = mdio_wire;
			mdc = 1'b1;
			repeat (half) @(negedge sys_clk);
		end
		mdc = 1'b0;
		// one extra low step, so that back-to-back calls never assign mdc twice in one time step
		@(negedge sys_clk);
	endtask : frame
endmodule : mgmt_host_model

// ### verification/channel_reset_status_regs_tb.sv
// self-checking bench for the channel reset and status register pair
// assumes the host model owns mdc; the data wire is pulled up when nobody drives it
`timescale 1ns/1ps

module channel_reset_status_regs_tb
	import chan_mgmt_pkg::*;
;
	logic         sys_clk;
	logic         sys_rst;
	logic         mdc;
	logic         host_drv;
	logic         mdio_wire;
	logic         mdio_out;
	logic         mdio_oe;
	logic [1:0]   chan_mode;
	chan_status_t chan_status;
	chan_resets_t chan_resets;
	logic [2:0]   seen;
	logic         seen_clr;
	logic [31:0]  lfsr;
	logic [15:0]  rword;
	logic [15:0]  wval;
	logic         teng;
	int           half;
	int           m;
	int           mismatches;
	int           n_checks;

	assign mdio_wire = mdio_oe ? mdio_out : host_drv;

	chan_mgmt_regs dut
	(
		.sys_clk     (sys_clk),
		.sys_rst     (sys_rst),
		.mdc         (mdc),
		.mdio_in     (mdio_wire),
		.mdio_out    (mdio_out),
		.mdio_oe     (mdio_oe),
		.chan_mode   (chan_mode),
		.chan_status (chan_status),
		.chan_resets (chan_resets)
	);

	mgmt_host_model host
	(
		.sys_clk   (sys_clk),
		.mdc       (mdc),
		.mdio_drv  (host_drv),
		.mdio_wire (mdio_wire)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// pulses are one mdc period long, so they are caught here rather than polled
	always @(posedge sys_clk)
		seen <= seen_clr ? 3'b000 : (seen | chan_resets);

	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : next_rand

	function automatic logic [15:0] exp_status(input logic [14:0] s, input logic [1:0] md);
		logic u;
		logic g;
		u = (md != MODE_1GKX);
		g = (md == MODE_10G) || (md == MODE_1GKX);
		return {s[14] & g, s[13:9], 1'b0, s[8], s[7] & u, s[6], s[5] & u, s[4:0]};
	endfunction : exp_status

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check16

	task automatic check3(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check3

	// seen has one driver; the clear is a request that the sampling process honours
	task automatic clear_seen;
		seen_clr = 1'b1;
		@(negedge sys_clk);
		seen_clr = 1'b0;
	endtask : clear_seen

	task automatic access(input logic [1:0] op, input logic [15:0] addr, input logic [15:0] wd);
		host.frame(OP_ADDRESS, 5'h00, addr, half, rword);
		host.frame(op, 5'h00, wd, half, rword);
	endtask : access

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (100000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end

	initial
	begin
		sys_rst = 1'b1;
		chan_mode = MODE_10G;
		chan_status = '0;
		seen_clr = 1'b1;
		lfsr = 32'hDBBB;
		half = 5;
		mismatches = 0;
		n_checks = 0;
		repeat (5) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge sys_clk);
		access(OP_READ, REG_SOFT_RESET, WORD_ZERO);
		check16(rword, 16'h0000);
		access(OP_READ, REG_LINK_STATUS, WORD_ZERO);
		check16(rword, 16'h0000);
		for (m = 0; m < 8; m++)
		begin
			lfsr = next_rand(lfsr);
			half = (m < 4) ? 5 : 8;
			chan_mode = m[1:0];
			chan_status = lfsr[30:16];
			teng = (m[1:0] == MODE_10G);
			wval = (m == 0) ? 16'hFFFF : lfsr[15:0] | ((m < 4) ? 16'h000E : 16'h0000);
			clear_seen();
			// mode is settled before the datapath reset is issued
			access(OP_WRITE, REG_SOFT_RESET, wval);
			check3(seen, {wval[3], wval[2] & teng, wval[1] & teng});
			access(OP_READ_INC, REG_SOFT_RESET, WORD_ZERO);
			check16(rword, wval & 16'h00F1);
			host.frame(OP_WRITE, 5'h00, ~wval, half, rword);
			host.frame(OP_READ, 5'h00, WORD_ZERO, half, rword);
			check16(rword, exp_status(chan_status, chan_mode));
		end
		// a write framed for another port must neither pulse nor store
		host.frame(OP_ADDRESS, 5'h00, REG_SOFT_RESET, half, rword);
		clear_seen();
		host.frame(OP_WRITE, 5'h01, 16'h000F, half, rword);
		check3(seen, 3'b000);
		access(OP_READ, REG_SOFT_RESET, WORD_ZERO);
		check16(rword, wval & 16'h00F1);
		access(OP_READ, 16'h0010, WORD_ZERO);
		check16(rword, 16'h0000);
		conclude();
	end
endmodule : channel_reset_status_regs_tb
